// ===== core/can_gen_pkg.sv
// Constants, register map and carrier types of the CAN general control block.
// Assumes one 100 MHz clock and a byte-wide register port with 3 address bits.
package can_gen_pkg;

  localparam int OBJECT_COUNT = 15;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] GENERAL_CONTROL_OFFSET = 3'h0;
  localparam logic [ADDR_W-1:0] GENERAL_STATUS_OFFSET = 3'h1;
  localparam logic [ADDR_W-1:0] GENERAL_INTERRUPT_FLAGS_OFFSET = 3'h2;
  localparam logic [ADDR_W-1:0] GENERAL_INTERRUPT_ENABLE_OFFSET = 3'h3;
  localparam logic [ADDR_W-1:0] OBJECT_IN_USE_LOW_OFFSET = 3'h4;
  localparam logic [ADDR_W-1:0] OBJECT_IN_USE_HIGH_OFFSET = 3'h5;

  // general_control fields
  localparam int CTRL_ABORT_BIT = 7;
  localparam int CTRL_OVERLOAD_BIT = 6;
  localparam int CTRL_TIME_MODE_BIT = 5;
  localparam int CTRL_SYNC_BIT = 4;
  localparam int CTRL_ONLY_SELECT_BIT = 3;
  localparam int CTRL_FACTORY_TEST_BIT = 2;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_SOFT_RESET_BIT = 0;

  // general_status fields
  localparam int STAT_OVERLOAD_BIT = 6;
  localparam int STAT_TX_BUSY_BIT = 4;
  localparam int STAT_RX_BUSY_BIT = 3;
  localparam int STAT_ENABLED_BIT = 2;
  localparam int STAT_BUS_OFF_BIT = 1;
  localparam int STAT_ERR_PASSIVE_BIT = 0;

  // general_interrupt_flags fields; bit 7 is the read-only summary
  localparam int FLAG_ANY_BIT = 7;
  localparam int FLAG_BUS_OFF_BIT = 6;
  localparam int FLAG_OVERRUN_BIT = 5;
  localparam int FLAG_BUFFER_BIT = 4;
  localparam int FLAG_STUFF_BIT = 3;
  localparam int FLAG_CRC_BIT = 2;
  localparam int FLAG_FORM_BIT = 1;
  localparam int FLAG_ACK_BIT = 0;
  localparam int FLAG_W = 7;

  // general_interrupt_enable fields
  localparam int IE_GLOBAL_BIT = 7;
  localparam int IE_BUS_OFF_BIT = 6;
  localparam int IE_RX_BIT = 5;
  localparam int IE_TX_BIT = 4;
  localparam int IE_OBJ_ERR_BIT = 3;
  localparam int IE_BUFFER_BIT = 2;
  localparam int IE_GEN_ERR_BIT = 1;
  localparam int IE_OVERRUN_BIT = 0;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 7'h00;
  localparam logic [OBJECT_COUNT-1:0] OBJECTS_NONE = 15'h0000;
  localparam logic [3:0] ENABLE_RUN_LAST = 4'hA;
  localparam logic [3:0] RUN_ZERO = 4'h0;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;
  localparam logic [2:0] STUFF_FIRST = 3'h1;
  localparam logic [15:0] TIMER_TOP = 16'hFFFF;
  localparam logic [15:0] TIMER_ZERO = 16'h0000;
  localparam logic RECESSIVE = 1'b1;

  // Protocol engine state and one-cycle events
  typedef struct packed {
    logic sof;
    logic eof_last;
    logic tx_active;
    logic rx_active;
    logic overload_active;
    logic bus_off;
    logic error_passive;
    logic crc_error;
    logic form_error;
    logic ack_error;
    logic stuff_window;
    logic buffer_done;
    logic rx_irq;
    logic tx_irq;
    logic obj_err_irq;
  } engine_status_t;

  // Per object events, one bit per message object
  typedef struct packed {
    logic [OBJECT_COUNT-1:0] turned_on;
    logic [OBJECT_COUNT-1:0] turned_off;
    logic [OBJECT_COUNT-1:0] config_written;
    logic [OBJECT_COUNT-1:0] transmit_done_flag;
    logic [OBJECT_COUNT-1:0] receive_done_flag;
    logic [OBJECT_COUNT-1:0] buffer_member;
  } object_events_t;

endpackage

// ===== core/can_general_ctrl.sv
// General control, status and interrupt flags of the CAN controller.
// Assumes a protocol engine beside it that supplies bit ticks, bus samples and events.
//
// What this block does
// - In time mode, capture strobe on start of frame if sync bit 0, else last end bit.
// - Only_select_a control bit 1 selects listening mode; 0 is normal operation.
// - Enable bit is a command; the enabled flag shows the mode really in force.
// - Standby waits for running transmission, then freezes object configuration.
// - Standby drives recessive, disables receiver, registers stay accessible.
// - Enable takes effect only after 11 consecutive recessive bits.
// - Soft reset bit resets the controller with hardware reset, then self clears.
// - Overload flag is high while our overload frame is sent, no interrupt.
// - Transmitter busy high while any frame, ack or interframe sent, no interrupt.
// - Receiver busy high while a frame is received or monitored, no interrupt.
// - Bus-off and error-passive status bits; only bus-off entry raises a flag.
// - Summary flag is OR of all interrupt sources except timer overrun.
// - Writable flags clear on writing 1; writing 0 keeps them.
// - Bus-off flag sets only on entering bus-off from error-passive.
// - Overrun flag sets on timer wrap; clears on write 1 or handler entry.
// - Buffer flag sets on buffer done; clears only after all configs rewritten.
// - Stuff flag sets on more than 5 equal consecutive bits.
// - CRC, form and ack error flags set from their engine detections.
// - Enable bits gate interrupts; bit 7 global for CAN_IRQ only, bit 0 alone gates timer overrun.
// - Object in-use bits set on enable, clear on done, disable, abort, standby.
// - Abort clears all in-use bits at once; running frame ends normally.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps

module can_general_ctrl
  import can_gen_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // Protocol engine side
  input wire logic BIT_TICK,
  input wire logic RX_BIT,
  input wire logic TX_BIT,
  input wire logic [15:0] TIMER_VALUE,
  input wire logic OVERRUN_HANDLER_ENTRY,
  input wire engine_status_t ENGINE,
  input wire object_events_t OBJECTS,
  // Control outputs
  output logic TXCAN,
  output logic RX_ENABLE,
  output logic CHANNEL_FROZEN,
  output logic ONLY_SELECT_A,
  output logic TEST_MODE,
  output logic OVERLOAD_REQUEST,
  output logic ABORT_REQUEST,
  output logic CAPTURE_TIMER,
  output logic CONTROLLER_RESET,
  output logic [OBJECT_COUNT-1:0] OBJECT_IN_USE,
  // Interrupt requests
  output logic CAN_IRQ,
  output logic TIMER_IRQ
);

  logic [DATA_W-1:0] control;
  logic [DATA_W-1:0] irq_enable;
  logic [FLAG_W-1:0] general_flags;
  logic soft_reset;
  logic ctrl_rst;
  logic enabled_state_flag;
  logic next_enabled;
  logic [3:0] recessive_run;
  logic [2:0] stuff_run;
  logic stuff_last;
  logic stuff_hit;
  logic overload_sending_flag;
  logic transmitter_busy;
  logic receiver_busy;
  logic bus_off_state;
  logic error_passive_state;
  logic [15:0] last_timer;
  logic [OBJECT_COUNT-1:0] rewritten;
  logic all_rewritten;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clear;
  logic any_interrupt_flag;
  logic wr_ctrl;
  logic wr_flags;
  logic abort_write;
  logic [DATA_W-1:0] read_value;
  logic [DATA_W-1:0] status_value;

  assign ctrl_rst = !RESET_N || soft_reset;
  assign wr_ctrl = WR && (ADDR == GENERAL_CONTROL_OFFSET);
  assign wr_flags = WR && (ADDR == GENERAL_INTERRUPT_FLAGS_OFFSET);
  assign abort_write = wr_ctrl && WDATA[CTRL_ABORT_BIT];

  // Soft reset pulse: one cycle, then self clearing
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= wr_ctrl && WDATA[CTRL_SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      CONTROLLER_RESET <= 1'b0;
    end else begin
      CONTROLLER_RESET <= wr_ctrl && WDATA[CTRL_SOFT_RESET_BIT];
    end
  end

  // Control register; the soft reset bit is never stored
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst) begin
      control <= REG_RESET;
    end else if (wr_ctrl) begin
      control <= WDATA;
      control[CTRL_SOFT_RESET_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (ctrl_rst) begin
      irq_enable <= REG_RESET;
    end else if (WR && ADDR == GENERAL_INTERRUPT_ENABLE_OFFSET) begin
      irq_enable <= WDATA;
    end
  end

  // Mode outputs to the engine
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst) begin
      ONLY_SELECT_A <= 1'b0;
      TEST_MODE <= 1'b0;
      OVERLOAD_REQUEST <= 1'b0;
      ABORT_REQUEST <= 1'b0;
    end else begin
      ONLY_SELECT_A <= control[CTRL_ONLY_SELECT_BIT];
      TEST_MODE <= control[CTRL_FACTORY_TEST_BIT];
      OVERLOAD_REQUEST <= control[CTRL_OVERLOAD_BIT];
      ABORT_REQUEST <= control[CTRL_ABORT_BIT];
    end
  end

  // Timer capture select, only meaningful in time mode
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst) begin
      CAPTURE_TIMER <= 1'b0;
    end else begin
      CAPTURE_TIMER <= control[CTRL_TIME_MODE_BIT] &&
        (control[CTRL_SYNC_BIT] ? ENGINE.eof_last : ENGINE.sof);
    end
  end

  // Recessive run counter for entering enable mode
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst || enabled_state_flag || !control[CTRL_ENABLE_BIT]) begin
      recessive_run <= RUN_ZERO;
    end else if (BIT_TICK) begin
      recessive_run <= (RX_BIT == RECESSIVE) ? recessive_run + 4'h1 : RUN_ZERO;
    end
  end

  always_comb begin
    next_enabled = enabled_state_flag;
    if (control[CTRL_ENABLE_BIT] && !enabled_state_flag) begin
      next_enabled = BIT_TICK && RX_BIT == RECESSIVE && recessive_run == ENABLE_RUN_LAST;
    end else if (!control[CTRL_ENABLE_BIT] && enabled_state_flag) begin
      next_enabled = ENGINE.tx_active;
    end
  end

  // Mode in force, receiver enable and freeze follow the command late
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst) begin
      enabled_state_flag <= 1'b0;
      RX_ENABLE <= 1'b0;
      CHANNEL_FROZEN <= 1'b1;
    end else begin
      enabled_state_flag <= next_enabled;
      RX_ENABLE <= next_enabled;
      CHANNEL_FROZEN <= !next_enabled;
    end
  end

  // Transmit pin: recessive in standby and in listening mode
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst) begin
      TXCAN <= RECESSIVE;
    end else begin
      TXCAN <= (enabled_state_flag && !control[CTRL_ONLY_SELECT_BIT]) ? TX_BIT : RECESSIVE;
    end
  end

  // Engine status mirrors
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst) begin
      overload_sending_flag <= 1'b0;
      transmitter_busy <= 1'b0;
      receiver_busy <= 1'b0;
      bus_off_state <= 1'b0;
      error_passive_state <= 1'b0;
    end else begin
      overload_sending_flag <= ENGINE.overload_active;
      transmitter_busy <= ENGINE.tx_active;
      receiver_busy <= ENGINE.rx_active;
      bus_off_state <= ENGINE.bus_off;
      error_passive_state <= ENGINE.error_passive;
    end
  end

  // Run length of equal bus bits inside the stuffed region
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst || !ENGINE.stuff_window) begin
      stuff_run <= 3'h0;
      stuff_last <= RECESSIVE;
    end else if (BIT_TICK) begin
      stuff_last <= RX_BIT;
      if (RX_BIT != stuff_last || stuff_run == 3'h0) begin
        stuff_run <= STUFF_FIRST;
      end else if (stuff_run != STUFF_LIMIT) begin
        stuff_run <= stuff_run + 3'h1;
      end
    end
  end

  assign stuff_hit = ENGINE.stuff_window && BIT_TICK && RX_BIT == stuff_last && stuff_run == STUFF_LIMIT;

  always_ff @(posedge CLOCK) begin
    if (ctrl_rst) begin
      last_timer <= TIMER_ZERO;
    end else begin
      last_timer <= TIMER_VALUE;
    end
  end

  // Configuration rewrite tracking of buffer objects
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst || ENGINE.buffer_done || flag_clear[FLAG_BUFFER_BIT]) begin
      rewritten <= OBJECTS_NONE;
    end else begin
      rewritten <= rewritten | OBJECTS.config_written;
    end
  end

  assign all_rewritten = (OBJECTS.buffer_member & ~rewritten) == OBJECTS_NONE;

  always_comb begin
    flag_set = FLAGS_RESET;
    flag_set[FLAG_BUS_OFF_BIT] = ENGINE.bus_off && !bus_off_state && error_passive_state;
    flag_set[FLAG_OVERRUN_BIT] = last_timer == TIMER_TOP && TIMER_VALUE == TIMER_ZERO;
    flag_set[FLAG_BUFFER_BIT] = ENGINE.buffer_done;
    flag_set[FLAG_STUFF_BIT] = stuff_hit;
    flag_set[FLAG_CRC_BIT] = ENGINE.crc_error;
    flag_set[FLAG_FORM_BIT] = ENGINE.form_error;
    flag_set[FLAG_ACK_BIT] = ENGINE.ack_error;
    flag_clear = wr_flags ? WDATA[FLAG_W-1:0] : FLAGS_RESET;
    flag_clear[FLAG_OVERRUN_BIT] = flag_clear[FLAG_OVERRUN_BIT] || OVERRUN_HANDLER_ENTRY;
    flag_clear[FLAG_BUFFER_BIT] = flag_clear[FLAG_BUFFER_BIT] && all_rewritten;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst) begin
      general_flags <= FLAGS_RESET;
    end else begin
      general_flags <= (general_flags & ~flag_clear) | flag_set;
    end
  end

  assign any_interrupt_flag = general_flags[FLAG_BUS_OFF_BIT] || general_flags[FLAG_BUFFER_BIT] ||
    (|general_flags[FLAG_STUFF_BIT:FLAG_ACK_BIT]) ||
    ENGINE.rx_irq || ENGINE.tx_irq || ENGINE.obj_err_irq;

  // Interrupt request lines gated by the enable register
  always_ff @(posedge CLOCK) begin
    if (ctrl_rst) begin
      CAN_IRQ <= 1'b0;
      TIMER_IRQ <= 1'b0;
    end else begin
      CAN_IRQ <= irq_enable[IE_GLOBAL_BIT] && (
        (irq_enable[IE_BUS_OFF_BIT] && general_flags[FLAG_BUS_OFF_BIT]) ||
        (irq_enable[IE_RX_BIT] && ENGINE.rx_irq) ||
        (irq_enable[IE_TX_BIT] && ENGINE.tx_irq) ||
        (irq_enable[IE_OBJ_ERR_BIT] && ENGINE.obj_err_irq) ||
        (irq_enable[IE_BUFFER_BIT] && general_flags[FLAG_BUFFER_BIT]) ||
        (irq_enable[IE_GEN_ERR_BIT] && (|general_flags[FLAG_STUFF_BIT:FLAG_ACK_BIT])));
      TIMER_IRQ <= irq_enable[IE_OVERRUN_BIT] && general_flags[FLAG_OVERRUN_BIT];
    end
  end

  // Object in-use bits; an enable event wins over any clear
  genvar i;
  generate
    for (i = 0; i < OBJECT_COUNT; i++) begin : g_obj
      always_ff @(posedge CLOCK) begin
        if (ctrl_rst) begin
          OBJECT_IN_USE[i] <= 1'b0;
        end else if (OBJECTS.turned_on[i]) begin
          OBJECT_IN_USE[i] <= 1'b1;
        end else if (OBJECTS.transmit_done_flag[i] || OBJECTS.receive_done_flag[i] ||
                     OBJECTS.turned_off[i] || abort_write || !enabled_state_flag) begin
          OBJECT_IN_USE[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    status_value = REG_RESET;
    status_value[STAT_OVERLOAD_BIT] = overload_sending_flag;
    status_value[STAT_TX_BUSY_BIT] = transmitter_busy;
    status_value[STAT_RX_BUSY_BIT] = receiver_busy;
    status_value[STAT_ENABLED_BIT] = enabled_state_flag;
    status_value[STAT_BUS_OFF_BIT] = bus_off_state;
    status_value[STAT_ERR_PASSIVE_BIT] = error_passive_state;
  end

  // Read mux; unmapped offsets and reserved bits read as zero
  always_comb begin
    read_value = REG_RESET;
    unique case (ADDR)
      GENERAL_CONTROL_OFFSET: read_value = control;
      GENERAL_STATUS_OFFSET: read_value = status_value;
      GENERAL_INTERRUPT_FLAGS_OFFSET: read_value = {any_interrupt_flag, general_flags};
      GENERAL_INTERRUPT_ENABLE_OFFSET: read_value = irq_enable;
      OBJECT_IN_USE_LOW_OFFSET: read_value = OBJECT_IN_USE[7:0];
      OBJECT_IN_USE_HIGH_OFFSET: read_value = {1'b0, OBJECT_IN_USE[OBJECT_COUNT-1:8]};
      default: read_value = REG_RESET;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      RDATA <= REG_RESET;
    end else begin
      RDATA <= RD ? read_value : REG_RESET;
    end
  end

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  sequence soft_req_s;
    wr_ctrl && WDATA[CTRL_SOFT_RESET_BIT];
  endsequence

  soft_reset_pulse_a: assert property (
    soft_req_s ##1 !(wr_ctrl && WDATA[CTRL_SOFT_RESET_BIT]) |-> soft_reset ##1 (!soft_reset && !enabled_state_flag))
    else $error("soft reset did not pulse for one cycle");

  standby_recessive_a: assert property (
    !enabled_state_flag && !next_enabled && !soft_reset |=> TXCAN == RECESSIVE && !RX_ENABLE)
    else $error("transmit not recessive in standby");

  enable_after_run_a: assert property (
    $rose(enabled_state_flag) && !$past(soft_reset) |->
      $past(recessive_run) == ENABLE_RUN_LAST && $past(RX_BIT) && $past(BIT_TICK))
    else $error("enabled without eleven recessive bits");

  standby_waits_tx_a: assert property (
    $fell(enabled_state_flag) && !$past(soft_reset) |-> !$past(ENGINE.tx_active))
    else $error("standby entered during transmission");

  bus_off_entry_a: assert property (
    $rose(general_flags[FLAG_BUS_OFF_BIT]) |-> $past(error_passive_state) && !$past(bus_off_state))
    else $error("bus-off flag set without error-passive entry");

  flag_write_zero_a: assert property (
    wr_flags && !WDATA[FLAG_CRC_BIT] && general_flags[FLAG_CRC_BIT] && !soft_reset
      |=> general_flags[FLAG_CRC_BIT])
    else $error("writing zero cleared a flag");

  flag_write_one_a: assert property (
    wr_flags && WDATA[FLAG_FORM_BIT] && !ENGINE.form_error && !soft_reset |=> !general_flags[FLAG_FORM_BIT])
    else $error("writing one did not clear a flag");

  sequence timer_wrap_s;
    TIMER_VALUE == TIMER_TOP ##1 TIMER_VALUE == TIMER_ZERO;
  endsequence

  overrun_set_a: assert property (
    timer_wrap_s ##0 !soft_reset |=> general_flags[FLAG_OVERRUN_BIT])
    else $error("timer wrap did not set overrun flag");

  buffer_clear_guard_a: assert property (
    general_flags[FLAG_BUFFER_BIT] && wr_flags && !all_rewritten && !soft_reset
      |=> general_flags[FLAG_BUFFER_BIT])
    else $error("buffer flag cleared before configs rewritten");

  abort_clears_a: assert property (
    abort_write && OBJECTS.turned_on == OBJECTS_NONE |=> OBJECT_IN_USE == OBJECTS_NONE)
    else $error("abort left objects in use");

  global_gate_a: assert property (
    !irq_enable[IE_GLOBAL_BIT] |=> !CAN_IRQ)
    else $error("interrupt raised with global enable off");

  summary_read_a: assert property (
    RD && ADDR == GENERAL_INTERRUPT_FLAGS_OFFSET |=> RDATA[FLAG_ANY_BIT] == $past(any_interrupt_flag))
    else $error("summary flag does not match sources");

  capture_sof_a: assert property (
    control[CTRL_TIME_MODE_BIT] && !control[CTRL_SYNC_BIT] && ENGINE.sof && !soft_reset |=> CAPTURE_TIMER)
    else $error("no timer capture on start of frame");

endmodule

// ===== tb/can_node_model.sv
// Far-side model: the other nodes on a wired-AND bus, plus the bit sample strobe.
// Assumes the bench clock; the bus rests recessive through its pull-up.
`timescale 1ns/1ps

module can_node_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus drive from our transmitter and from the other nodes
  input wire logic txcan,
  input wire logic node_dominant,
  // Sampled bus towards the block
  output logic bit_tick,
  output logic rx_bit
);
  logic [1:0] phase;

  // One bus bit every four clocks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Dominant from any node wins; otherwise the pull-up leaves it recessive
  always_ff @(posedge clk) begin
    bit_tick <= rst_n && phase == 2'h3;
    rx_bit <= txcan & ~node_dominant;
  end
endmodule

// ===== tb/can_general_ctrl_tb.sv
// Self-checking bench of the CAN general control block.
// Assumes the package and the bus model are compiled first.
`timescale 1ns/1ps

module can_general_ctrl_tb;
  import can_gen_pkg::*;
  typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] v;} note_t;
  localparam logic [2:0] CTL = GENERAL_CONTROL_OFFSET;
  localparam logic [2:0] STA = GENERAL_STATUS_OFFSET;
  localparam logic [2:0] FLG = GENERAL_INTERRUPT_FLAGS_OFFSET;
  localparam logic [2:0] IEN = GENERAL_INTERRUPT_ENABLE_OFFSET;
  string rname[8] = '{"control", "status", "flags", "enable", "use_low", "use_high", "gap6", "gap7"};
  logic clock = 1'h0, reset_n = 1'h0, wr = 1'h0, rd = 1'h0, rd_d = 1'h0;
  logic tx_bit = 1'h1, handler = 1'h0, dom = 1'h0, tick, rx_bit;
  logic [ADDR_W-1:0] addr = 3'h0;
  logic [DATA_W-1:0] wdata = 8'h00, rdata;
  logic [15:0] timer = 16'h0000;
  engine_status_t eng = '0;
  object_events_t obj = '0;
  logic txcan, rx_en, frozen, only_sel, test_mode, capture, ctl_reset, can_irq, timer_irq, abort_req, ovl_req;
  logic [OBJECT_COUNT-1:0] in_use;
  logic [2:0] lv;
  logic [7:0] cap_cfg[3] = '{8'h22, 8'h32, 8'h12};
  note_t notes[$];
  note_t cur;
  int miscompares = 0, num_checks = 0, seed = 40, pulses;

  can_general_ctrl DUT (.CLOCK(clock), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .BIT_TICK(tick), .RX_BIT(rx_bit), .TX_BIT(tx_bit), .TIMER_VALUE(timer),
    .OVERRUN_HANDLER_ENTRY(handler), .ENGINE(eng), .OBJECTS(obj), .TXCAN(txcan), .RX_ENABLE(rx_en),
    .CHANNEL_FROZEN(frozen), .ONLY_SELECT_A(only_sel), .TEST_MODE(test_mode), .OVERLOAD_REQUEST(ovl_req),
    .ABORT_REQUEST(abort_req), .CAPTURE_TIMER(capture), .CONTROLLER_RESET(ctl_reset),
    .OBJECT_IN_USE(in_use), .CAN_IRQ(can_irq), .TIMER_IRQ(timer_irq));

  can_node_model bus (.clk(clock), .rst_n(reset_n), .txcan(txcan), .node_dominant(dom), .bit_tick(tick),
    .rx_bit(rx_bit));

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic chk(string what, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pin(string what, logic seen, logic exp);
    chk(what, {7'h00, seen}, {7'h00, exp});
  endtask

  task automatic cycles(int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask

  // Read data is noted here and compared by the monitor a cycle later
  task automatic rd_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    notes.push_back('{a, exp});
    @(posedge clock);
    rd <= 1'h0;
  endtask

  task automatic pulse(engine_status_t e, object_events_t o);
    @(posedge clock);
    eng <= eng | e;
    obj <= obj | o;
    @(posedge clock);
    eng <= eng & ~e;
    obj <= obj & ~o;
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) rd_d <= rd;

  always @(negedge clock) begin
    if (rd_d && notes.size() > 0) begin
      cur = notes.pop_front();
      chk(rname[cur.a], rdata, cur.v);
    end
  end

  initial begin
    #100000;
    miscompares++;
    stop_test();
  end

  initial begin
    cycles(10);
    pin("TXCAN", txcan, 1'h1);
    pin("CHANNEL_FROZEN", frozen, 1'h1);
    reset_n <= 1'h1;
    // Read-only and unmapped places ignore writes
    foreach (cap_cfg[i]) wr_reg(3'h4 + 3'(i), 8'hFF);
    wr_reg(STA, 8'hFF);
    for (int a = 0; a < 8; a++) rd_reg(a[2:0], 8'h00);
    // Enable waits for 11 recessive bits after the bus goes quiet; test bit stays clear
    dom <= 1'h1;
    wr_reg(CTL, 8'h02);
    tx_bit <= 1'h0;
    cycles(20);
    dom <= 1'h0;
    cycles(36);
    rd_reg(STA, 8'h00);
    pin("TXCAN", txcan, 1'h1);
    pin("RX_ENABLE", rx_en, 1'h0);
    cycles(48);
    rd_reg(STA, 8'h04);
    pin("RX_ENABLE", rx_en, 1'h1);
    pin("TXCAN", txcan, 1'h0);
    pin("TEST_MODE", test_mode, 1'h0);
    wr_reg(CTL, 8'h4A);
    cycles(2);
    pin("TXCAN", txcan, 1'h1);
    pin("ONLY_SELECT_A", only_sel, 1'h1);
    pin("OVERLOAD_REQUEST", ovl_req, 1'h1);
    wr_reg(CTL, 8'h02);
    tx_bit <= 1'h1;
    // Busy and overload levels raise no flag
    wr_reg(IEN, 8'hFE);
    repeat (8) begin
      lv = 3'($random(seed));
      eng.tx_active <= lv[0];
      eng.rx_active <= lv[1];
      eng.overload_active <= lv[2];
      cycles(2);
      rd_reg(STA, {1'h0, lv[2], 1'h0, lv[0], lv[1], 3'h4});
    end
    rd_reg(FLG, 8'h00);
    // Object sources need the global enable
    for (int i = 0; i < 3; i++) begin
      {eng.rx_irq, eng.tx_irq, eng.obj_err_irq} <= 3'h4 >> i;
      wr_reg(IEN, 8'h20 >> i);
      cycles(3);
      pin("CAN_IRQ", can_irq, 1'h0);
      wr_reg(IEN, 8'h80 | (8'h20 >> i));
      cycles(3);
      pin("CAN_IRQ", can_irq, 1'h1);
    end
    eng <= '0;
    // General error flags, write-one clear
    wr_reg(IEN, 8'h82);
    for (int i = 0; i < 3; i++) begin
      lv = 3'h1 << i;
      pulse('{ack_error: lv[0], form_error: lv[1], crc_error: lv[2], default: 1'h0}, '0);
      cycles(2);
      pin("CAN_IRQ", can_irq, 1'h1);
      wr_reg(FLG, 8'h00);
      rd_reg(FLG, 8'h80 | 8'(lv));
      wr_reg(FLG, 8'(lv));
      rd_reg(FLG, 8'h00);
    end
    eng.stuff_window <= 1'h1;
    dom <= 1'h1;
    cycles(32);
    rd_reg(FLG, 8'h88);
    eng.stuff_window <= 1'h0;
    dom <= 1'h0;
    wr_reg(FLG, 8'h08);
    // Timer wrap: own enable, not in the summary
    wr_reg(IEN, 8'h01);
    timer <= 16'hFFFF;
    cycles(2);
    timer <= 16'h0000;
    cycles(3);
    pin("TIMER_IRQ", timer_irq, 1'h1);
    pin("CAN_IRQ", can_irq, 1'h0);
    rd_reg(FLG, 8'h20);
    @(posedge clock);
    handler <= 1'h1;
    @(posedge clock);
    handler <= 1'h0;
    rd_reg(FLG, 8'h00);
    // Bus-off counts only when entered from error passive
    eng.bus_off <= 1'h1;
    cycles(2);
    rd_reg(STA, 8'h06);
    rd_reg(FLG, 8'h00);
    eng.bus_off <= 1'h0;
    eng.error_passive <= 1'h1;
    cycles(2);
    eng.bus_off <= 1'h1;
    cycles(2);
    rd_reg(STA, 8'h07);
    rd_reg(FLG, 8'hC0);
    eng <= '0;
    wr_reg(FLG, 8'h40);
    // Buffer flag clears only once every member object is rewritten
    obj.buffer_member <= 15'h0003;
    pulse('{buffer_done: 1'h1, default: 1'h0}, '0);
    wr_reg(FLG, 8'h10);
    rd_reg(FLG, 8'h90);
    pulse('0, '{config_written: 15'h0003, default: '0});
    wr_reg(FLG, 8'h10);
    rd_reg(FLG, 8'h00);
    // Timer capture point by sync select, none outside time mode
    foreach (cap_cfg[s]) begin
      wr_reg(CTL, cap_cfg[s]);
      pulse('{sof: 1'h1, default: 1'h0}, '0);
      #1 pin("CAPTURE_TIMER", capture, s == 0);
      pulse('{eof_last: 1'h1, default: 1'h0}, '0);
      #1 pin("CAPTURE_TIMER", capture, s == 1);
    end
    wr_reg(CTL, 8'h02);
    // Objects in use, done, abort
    pulse('0, '{turned_on: 15'h4081, default: '0});
    rd_reg(3'h4, 8'h81);
    rd_reg(3'h5, 8'h40);
    chk("OBJECT_IN_USE", in_use[7:0], 8'h81);
    pulse('0, '{transmit_done_flag: 15'h0001, default: '0});
    rd_reg(3'h4, 8'h80);
    wr_reg(CTL, 8'h82);
    rd_reg(3'h4, 8'h00);
    rd_reg(3'h5, 8'h00);
    pin("ABORT_REQUEST", abort_req, 1'h1);
    // Standby after abort with receiver idle waits for the running transmission
    eng.tx_active <= 1'h1;
    wr_reg(CTL, 8'h00);
    cycles(4);
    rd_reg(STA, 8'h14);
    eng.tx_active <= 1'h0;
    tx_bit <= 1'h0;
    cycles(3);
    rd_reg(STA, 8'h00);
    pin("CHANNEL_FROZEN", frozen, 1'h1);
    pin("TXCAN", txcan, 1'h1);
    rd_reg(IEN, 8'h01);
    // Soft reset pulses once and clears the registers
    wr_reg(IEN, 8'h5A);
    wr_reg(CTL, 8'h01);
    pulses = 0;
    repeat (6) begin
      #1 pulses += ctl_reset;
      @(posedge clock);
    end
    chk("reset pulses", 8'(pulses), 8'h01);
    rd_reg(CTL, 8'h00);
    rd_reg(IEN, 8'h00);
    cycles(4);
    stop_test();
  end
endmodule
